// File: rtl/tws_defs.svh
// shared constants for the two-wire register port
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH
`define TWS_ADDR_FIXED 6'h26
`define TWS_IDX_W 7
`define TWS_NREG 20
`define TWS_REG_ZERO_STAT 7'h0e
`define TWS_REG_RSV0 7'h00
`define TWS_REG_RSV1 7'h0b
`define TWS_REG_RSV2 7'h0f
`define TWS_T_LOW_NS 4700
`define TWS_T_HIGH_NS 4000
`define TWS_CLK_NS 8
`define TWS_HALF_CYC ((`TWS_T_LOW_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
`endif

// File: rtl/tws_pkg.sv
// types for the two-wire register port
package tws_pkg;
  typedef enum logic [6:0] {
    TS_IDLE = 7'b0000001,
    TS_ADDR = 7'b0000010,
    TS_AACK = 7'b0000100,
    TS_RX = 7'b0001000,
    TS_RACK = 7'b0010000,
    TS_TX = 7'b0100000,
    TS_TACK = 7'b1000000
  } tws_dev_st_t;
  typedef enum logic [8:0] {
    TM_IDLE = 9'b000000001,
    TM_START = 9'b000000010,
    TM_BIT_LO = 9'b000000100,
    TM_BIT_HI = 9'b000001000,
    TM_NEXT = 9'b000010000,
    TM_RS = 9'b000100000,
    TM_STOP_LO = 9'b001000000,
    TM_STOP_HI = 9'b010000000,
    TM_DONE = 9'b100000000
  } tws_mst_st_t;
endpackage

// File: rtl/tws_bus_if.sv
// two-wire bus carrier; open-drain levels resolved here
`timescale 1ns/10ps
interface tws_bus_if;
  logic scl_o;
  logic scl_oe;
  logic sda_mst_o;
  logic sda_mst_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic scl;
  logic sda;
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_mst_oe & ~sda_mst_o) | (sda_dev_oe & ~sda_dev_o));
  modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport mst (input scl, input sda, output scl_o, output scl_oe, output sda_mst_o, output sda_mst_oe);
endinterface

// File: rtl/tws_dev.sv
// two-wire target port holding the mode-control registers
`timescale 1ns/10ps
`include "tws_defs.svh"
module tws_dev
  import tws_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  tws_bus_if.dev bus,
  input wire logic control_port_select,
  input wire logic addr_sel,
  input wire logic [7:0] zero_status,
  output logic [8*`TWS_NREG-1:0] reg_flat,
  output logic wr_strobe,
  output logic [6:0] wr_index
);
  ////////////////////////////////////////////////////////////////
  // pin synchronisers; the first stage feeds only the second
  logic [1:0] scl_s_q, sda_s_q, sel_s_q, adr_s_q;
  logic scl_q, sda_q;
  always_ff @(posedge mclk)
  begin
    scl_s_q <= {scl_s_q[0], bus.scl};
    sda_s_q <= {sda_s_q[0], bus.sda};
    sel_s_q <= {sel_s_q[0], control_port_select};
    adr_s_q <= {adr_s_q[0], addr_sel};
    scl_q <= scl_s_q[1];
    sda_q <= sda_s_q[1];
  end
  wire port_en = sel_s_q[1];
  wire scl_rise = scl_s_q[1] & ~scl_q;
  wire scl_fall = ~scl_s_q[1] & scl_q;
  wire start_ev = port_en & scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
  wire stop_ev = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];
  wire [6:0] own_addr = {`TWS_ADDR_FIXED, adr_s_q[1]};
  ////////////////////////////////////////////////////////////////
  // index decode used only by the write commit; reads decode the index separately in rd_val
  function automatic logic idx_defined(input logic [6:0] i);
    idx_defined = (i < 7'(`TWS_NREG)) && i != `TWS_REG_RSV0 && i != `TWS_REG_RSV1
      && i != `TWS_REG_RSV2 && i != `TWS_REG_ZERO_STAT;
  endfunction
  tws_dev_st_t st_q, st_d;
  logic [7:0] sh_q;
  logic [2:0] cnt_q;
  logic [6:0] idx_q;
  logic byte_no_q; // 0: index byte, 1: data byte
  logic rw_q, drive_q, ack_q, done_q;
  logic [7:0] regs_q [`TWS_NREG];
  wire [7:0] sh_next = {sh_q[6:0], sda_s_q[1]};
  // the whole address byte already sits in the shifter when the eighth clock falls
  wire addr_hit = sh_q[7:1] == own_addr;
  wire [7:0] rd_val = (idx_q == `TWS_REG_ZERO_STAT) ? zero_status
    : (idx_q < 7'(`TWS_NREG)) ? regs_q[idx_q[4:0]] : 8'h00;
  wire commit = st_q == TS_RACK && scl_fall && byte_no_q && idx_defined(idx_q);
  ////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      TS_IDLE: st_d = st_q;
      TS_ADDR: if (scl_fall && cnt_q == 3'h0 && done_q) st_d = addr_hit ? TS_AACK : TS_IDLE;
      TS_AACK: if (scl_fall) st_d = rw_q ? TS_TX : TS_RX;
      TS_RX: if (scl_fall && cnt_q == 3'h0 && done_q) st_d = TS_RACK;
      TS_RACK: if (scl_fall) st_d = byte_no_q ? TS_IDLE : TS_RX;
      TS_TX: if (scl_fall && cnt_q == 3'h0 && done_q) st_d = TS_TACK;
      TS_TACK: if (scl_fall) st_d = ack_q ? TS_IDLE : TS_TX;
    endcase
    if (start_ev)
      st_d = TS_ADDR;
    else if (stop_ev || !port_en)
      st_d = TS_IDLE;
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_q <= TS_IDLE;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      idx_q <= 7'h00;
      byte_no_q <= 1'b0;
      rw_q <= 1'b0;
      drive_q <= 1'b0;
      ack_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      if (start_ev)
      begin
        cnt_q <= 3'h0;
        done_q <= 1'b0;
        byte_no_q <= 1'b0;
      end
      if (scl_rise && (st_q == TS_ADDR || st_q == TS_RX))
      begin
        sh_q <= sh_next;
        cnt_q <= cnt_q + 3'h1;
        done_q <= cnt_q == 3'h7;
        if (st_q == TS_ADDR && cnt_q == 3'h7)
          rw_q <= sda_s_q[1];
      end
      if (scl_rise && st_q == TS_TX)
      begin
        cnt_q <= cnt_q + 3'h1;
        done_q <= cnt_q == 3'h7;
      end
      if (scl_rise && st_q == TS_TACK)
        ack_q <= sda_s_q[1];
      if (scl_fall && st_q == TS_RACK && !byte_no_q)
      begin
        idx_q <= sh_q[6:0];
        byte_no_q <= 1'b1;
      end
      if (scl_fall && (st_q == TS_AACK || st_q == TS_RACK || st_q == TS_TACK))
        done_q <= 1'b0;
      if (scl_fall && st_q == TS_AACK && rw_q)
        sh_q <= rd_val;
      else if (scl_fall && st_q == TS_TX && cnt_q != 3'h0)
        sh_q <= {sh_q[6:0], 1'b0};
      // data changes only while the clock is low
      if (scl_fall)
        drive_q <= (st_d == TS_AACK) || (st_d == TS_RACK)
          || (st_d == TS_TX && !(st_q == TS_AACK ? rd_val[7] : (st_q == TS_TX ? sh_q[6] : sh_q[7])));
      if (st_d == TS_IDLE)
        drive_q <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////
  // register store; only a full acknowledged data byte lands
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int i = 0; i < `TWS_NREG; i++)
        regs_q[i] <= 8'h00;
      wr_strobe <= 1'b0;
      wr_index <= 7'h00;
    end
    else
    begin
      wr_strobe <= commit;
      if (commit)
      begin
        regs_q[idx_q[4:0]] <= sh_q;
        wr_index <= idx_q;
      end
    end
  end
  always_comb
  begin
    for (int i = 0; i < `TWS_NREG; i++)
      reg_flat[8*i +: 8] = regs_q[i];
  end
  // open drain: only ever pull low, never the clock
  assign bus.sda_dev_o = 1'b0;
  assign bus.sda_dev_oe = drive_q;
endmodule // tws_dev

// File: rtl/tws_mst.sv
// two-wire host end: issues single-register writes and reads
`timescale 1ns/10ps
`include "tws_defs.svh"
module tws_mst
  import tws_pkg::*;
#(
  parameter int HALF = `TWS_HALF_CYC
)
(
  input wire logic mclk,
  input wire logic rst,
  tws_bus_if.mst bus,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_read,
  input wire logic [6:0] req_target,
  input wire logic [6:0] req_index,
  input wire logic [7:0] req_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_nack
);
  logic [1:0] sda_s_q;
  always_ff @(posedge mclk)
    sda_s_q <= {sda_s_q[0], bus.sda};
  tws_mst_st_t st_q;
  logic [15:0] tm_q;
  logic [3:0] bit_q;
  logic [1:0] phase_q; // 0 addr-w,1 index,2 data or addr-r,3 read data
  logic [8:0] sh_q;
  logic rd_q, scl_q, sda_q, nack_q;
  logic [6:0] tgt_q, idx_q;
  logic [7:0] wd_q, rd_data_q;
  wire tick = tm_q == 16'(HALF);
  assign req_ready = st_q == TM_IDLE;
  function automatic logic [8:0] frame_byte(input logic [1:0] ph, input logic rd, input logic [6:0] t,
    input logic [6:0] ix, input logic [7:0] wd);
    unique case (ph)
      2'd0: frame_byte = {t, 1'b0, 1'b1};
      2'd1: frame_byte = {1'b0, ix, 1'b1};
      2'd2: frame_byte = rd ? {t, 1'b1, 1'b1} : {wd, 1'b1};
      default: frame_byte = {8'hff, 1'b1}; // nack after read data
    endcase
  endfunction
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_q <= TM_IDLE;
      tm_q <= 16'h0;
      bit_q <= 4'h0;
      phase_q <= 2'd0;
      sh_q <= 9'h1ff;
      rd_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      nack_q <= 1'b0;
      tgt_q <= 7'h00;
      idx_q <= 7'h00;
      wd_q <= 8'h00;
      rd_data_q <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      rsp_nack <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      tm_q <= tick ? 16'h0 : tm_q + 16'h1;
      unique case (st_q)
        TM_IDLE:
        begin
          tm_q <= 16'h0;
          if (req_valid)
          begin
            rd_q <= req_read;
            tgt_q <= req_target;
            idx_q <= req_index;
            wd_q <= req_wdata;
            nack_q <= 1'b0;
            phase_q <= 2'd0;
            st_q <= TM_START;
          end
        end
        TM_START:
          if (tick)
          begin
            sda_q <= 1'b0;
            st_q <= TM_BIT_LO;
            bit_q <= 4'h0;
            sh_q <= frame_byte(phase_q, rd_q, tgt_q, idx_q, wd_q);
          end
        // data moves one tick after the clock falls, half way through the low phase, never with it
        TM_BIT_LO:
          if (tick && scl_q)
            scl_q <= 1'b0;
          else if (tick)
          begin
            sda_q <= sh_q[8];
            st_q <= TM_BIT_HI;
          end
        TM_BIT_HI:
          if (tick && scl_q == 1'b0)
            scl_q <= 1'b1;
          else if (tick)
          begin
            sh_q <= {sh_q[7:0], 1'b1};
            if (phase_q == 2'd3 && bit_q < 4'h8)
              rd_data_q <= {rd_data_q[6:0], sda_s_q[1]};
            if (bit_q == 4'h8 && phase_q != 2'd3 && sda_s_q[1])
              nack_q <= 1'b1;
            bit_q <= bit_q + 4'h1;
            st_q <= bit_q == 4'h8 ? TM_NEXT : TM_BIT_LO;
          end
        TM_NEXT:
        begin
          scl_q <= 1'b0;
          if (nack_q || phase_q == 2'd3 || (phase_q == 2'd2 && !rd_q))
            st_q <= TM_STOP_LO;
          else if (phase_q == 2'd1 && rd_q)
            st_q <= TM_RS;
          else
          begin
            phase_q <= phase_q + 2'd1;
            bit_q <= 4'h0;
            sh_q <= frame_byte(phase_q + 2'd1, rd_q, tgt_q, idx_q, wd_q);
            st_q <= TM_BIT_LO;
          end
          tm_q <= 16'h0;
        end
        TM_RS:
          if (tick && scl_q == 1'b0 && !sda_q)
            sda_q <= 1'b1;
          else if (tick && sda_q && !scl_q)
            scl_q <= 1'b1;
          else if (tick)
          begin
            phase_q <= 2'd2;
            st_q <= TM_START;
          end
        TM_STOP_LO:
          if (tick && sda_q)
            sda_q <= 1'b0;
          else if (tick)
          begin
            scl_q <= 1'b1;
            st_q <= TM_STOP_HI;
          end
        TM_STOP_HI:
          if (tick)
          begin
            sda_q <= 1'b1;
            st_q <= TM_DONE;
          end
        TM_DONE:
          if (tick)
          begin
            rsp_valid <= 1'b1;
            rsp_nack <= nack_q;
            rsp_rdata <= rd_data_q;
            st_q <= TM_IDLE;
          end
      endcase
      if (st_q == TM_NEXT && phase_q == 2'd2 && rd_q && !nack_q)
        phase_q <= 2'd3;
    end
  end
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = ~scl_q;
  assign bus.sda_mst_o = 1'b0;
  assign bus.sda_mst_oe = ~sda_q;
endmodule // tws_mst

// File: verification/tws_assertions.sv
// bus-level checks between host and target ends of the two-wire port
`timescale 1ns/10ps
module tws_assertions
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_mst_o,
  input wire logic sda_mst_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // target data may only move while the clock is low
  dev_change_low_a: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("target moved data with clock high");
  dev_stable_high_a: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("target data unstable in high phase");
  // at most one byte plus ack, so a stuck driver shows here
  dev_release_a: assert property ($rose(sda_dev_oe) |-> ##[1:600] !sda_dev_oe)
    else $error("target held data line too long");
  pull_low_a: assert property (!(scl_o | sda_mst_o | sda_dev_o))
    else $error("a driver tried to force a high level");
  start_hold_a: assert property (scl && $fell(sda) |-> scl[*4] ##0 !sda_dev_oe)
    else $error("start not held or target drove it");
  clock_low_a: assert property ($fell(scl) |-> !scl[*4])
    else $error("clock low phase too short");
  clock_high_a: assert property ($rose(scl) |-> scl[*4])
    else $error("clock high phase too short");
  stop_free_a: assert property (scl && $rose(sda) |-> !sda_dev_oe && !$past(sda_dev_oe))
    else $error("target drove data at stop");
  ////////////////////////////////////////////////////////////
  cover property ($rose(sda_dev_oe));
  cover property (scl && $fell(sda));
  cover property (scl && $rose(sda));
endmodule // tws_assertions

// File: verification/i2c_register_slave_tb.sv
// self-checking bench joining the host and target ends of the two-wire port
`timescale 1ns/10ps
module i2c_register_slave_tb;
  import tws_pkg::*;
  typedef struct packed {logic sel; logic rd; logic [6:0] tgt; logic [6:0] idx; logic [7:0] wd; logic nack;} tws_row_t;
  localparam logic [7:0] ZS = 8'hc3;
  // sel, read, target, index, data, nack expected
  tws_row_t rows [14] = '{
    '{1'h0, 1'h0, 7'h4c, 7'h01, 8'ha5, 1'h0}, '{1'h0, 1'h1, 7'h4c, 7'h01, 8'h00, 1'h0},
    '{1'h0, 1'h0, 7'h4d, 7'h02, 8'h11, 1'h1}, '{1'h1, 1'h0, 7'h4d, 7'h02, 8'h3c, 1'h0},
    '{1'h1, 1'h1, 7'h4d, 7'h02, 8'h00, 1'h0}, '{1'h1, 1'h0, 7'h4c, 7'h05, 8'h77, 1'h1},
    '{1'h0, 1'h0, 7'h4c, 7'h15, 8'h33, 1'h0}, '{1'h0, 1'h1, 7'h4c, 7'h0b, 8'h00, 1'h0},
    '{1'h0, 1'h1, 7'h4c, 7'h0e, 8'h00, 1'h0}, '{1'h0, 1'h0, 7'h4c, 7'h0e, 8'hff, 1'h0},
    '{1'h0, 1'h0, 7'h4c, 7'h13, 8'h7e, 1'h0}, '{1'h0, 1'h1, 7'h4c, 7'h13, 8'h00, 1'h0},
    '{1'h0, 1'h0, 7'h4c, 7'h14, 8'h55, 1'h0}, '{1'h0, 1'h0, 7'h0a, 7'h01, 8'h66, 1'h1}};
  logic mclk, rst, ctl_sel, addr_sel, wr_strobe, req_valid, req_ready, req_read, rsp_valid, rsp_nack;
  logic [6:0] req_target, req_index, wr_index;
  logic [7:0] req_wdata, rsp_rdata;
  logic [159:0] reg_flat;
  logic [7:0] model [20];
  int errors, compares, strobes, commits;
  ////////////////////////////////////////////////////////////
  tws_bus_if tws_bus_if_inst ();
  tws_dev tws_dev_inst (.mclk(mclk), .rst(rst), .bus(tws_bus_if_inst), .control_port_select(ctl_sel),
    .addr_sel(addr_sel), .zero_status(ZS), .reg_flat(reg_flat), .wr_strobe(wr_strobe), .wr_index(wr_index));
  // short clock phases keep the run brief; the target needs only four cycles a phase
  tws_mst #(.HALF(8)) tws_mst_inst (.mclk(mclk), .rst(rst), .bus(tws_bus_if_inst), .req_valid(req_valid),
    .req_ready(req_ready), .req_read(req_read), .req_target(req_target), .req_index(req_index),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack));
  tws_assertions tws_assertions_inst (.mclk(mclk), .rst(rst), .scl(tws_bus_if_inst.scl),
    .sda(tws_bus_if_inst.sda), .scl_o(tws_bus_if_inst.scl_o), .scl_oe(tws_bus_if_inst.scl_oe),
    .sda_mst_o(tws_bus_if_inst.sda_mst_o), .sda_mst_oe(tws_bus_if_inst.sda_mst_oe),
    .sda_dev_o(tws_bus_if_inst.sda_dev_o), .sda_dev_oe(tws_bus_if_inst.sda_dev_oe));
  ////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) if (wr_strobe === 1'h1) strobes++;
  task automatic chk(input string nm, input logic [159:0] seen, input logic [159:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic logic defd(input logic [6:0] ix);
    return ix > 7'h00 && ix < 7'h14 && ix != 7'h0b && ix != 7'h0e && ix != 7'h0f;
  endfunction
  ////////////////////////////////////////////////////////////
  task automatic run(input tws_row_t r);
    logic [159:0] flat;
    logic [7:0] exp;
    @(negedge mclk);
    addr_sel = r.sel;
    req_valid = 1'h1;
    req_read = r.rd;
    req_target = r.tgt;
    req_index = r.idx;
    req_wdata = r.wd;
    while (req_ready !== 1'h1) @(negedge mclk);
    @(negedge mclk);
    req_valid = 1'h0;
    while (rsp_valid !== 1'h1) @(negedge mclk);
    chk("rsp_nack", rsp_nack, r.nack);
    exp = (r.idx == 7'h0e) ? ZS : ((r.idx < 7'h14) ? model[r.idx[4:0]] : 8'h00);
    if (r.rd && !r.nack) chk("rsp_rdata", rsp_rdata, exp);
    if (!r.rd && !r.nack && defd(r.idx))
    begin
      model[r.idx[4:0]] = r.wd;
      commits++;
      chk("wr_index", wr_index, r.idx);
    end
    foreach (model[i]) flat[8*i+:8] = model[i];
    chk("reg_flat", reg_flat, flat);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'h1;
    ctl_sel = 1'h1;
    addr_sel = 1'h0;
    req_valid = 1'h0;
    req_read = 1'h0;
    req_target = 7'h00;
    req_index = 7'h00;
    req_wdata = 8'h00;
    foreach (model[i]) model[i] = 8'h00;
    repeat (5) @(negedge mclk);
    rst = 1'h0;
    foreach (rows[i]) run(rows[i]);
    // port deselected: the target must stay silent
    ctl_sel = 1'h0;
    run('{1'h0, 1'h0, 7'h4c, 7'h02, 8'h99, 1'h1});
    ctl_sel = 1'h1;
    chk("strobes", strobes, commits);
    rst = 1'h1;
    repeat (5) @(negedge mclk);
    rst = 1'h0;
    @(negedge mclk);
    chk("reg_flat after reset", reg_flat, 160'h0);
    conclude;
  end
  initial
  begin
    repeat (60000) @(posedge mclk);
    errors++;
    conclude;
  end
endmodule // i2c_register_slave_tb
